// ### hdl/pto_timing_regs.sv
// Operation
// - Port 0 clock-post time is the automatic value unless bit 7 is set, then bits 6:0.
// - Port 0 data-prepare time is the automatic value unless bit 7 is set, then bits 6:0.
// - Port 0 data-zero time is the automatic value unless bit 7 is set, then bits 6:0.
// - Port 0 data-trail time is the automatic value unless bit 7 is set, then bits 6:0.
// - Port 0 data-exit time is the automatic value unless bit 7 is set, then bits 6:0.
// - Port 0 low-power pulse time is the automatic value unless bit 7 is set, then bits 6:0.
// - Port 1 clock-prepare time is the automatic value unless bit 7 is set, then bits 6:0.
// - Port 1 clock-zero time is the automatic value unless bit 7 is set, then bits 6:0.
// - With override clear, value writes are ignored and reads return the automatic value.
// - With override set, the value field is read/write and drives the parameter.
// - Reset values equal the automatic values at the 800 Mbps lane rate.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module pto_timing_regs (
    input  wire logic                 CLK,
    input  wire logic                 RESET_N,
    input  wire logic                 CE,
    input  wire pto_pkg::pto_rate_t   LANE_RATE,
    input  wire logic [7:0]           ADDR,
    input  wire logic [7:0]           WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output logic [7:0]                RDATA,
    output pto_pkg::pto_timing_t      TIMING
);

    logic [6:0]          auto_q [pto_pkg::NUM_REGS];
    logic [6:0]          val_q  [pto_pkg::NUM_REGS];
    logic                ovr_q  [pto_pkg::NUM_REGS];
    logic [6:0]          eff    [pto_pkg::NUM_REGS];
    logic [7:0]          rdata_q;
    pto_pkg::pto_timing_t timing_q;
    logic                hit;
    logic [2:0]          hit_idx;

    function automatic logic [4:0] rate_mult(input pto_pkg::pto_rate_t rate);
        case (rate)
            pto_pkg::RATE_400:  rate_mult = pto_pkg::MULT_400;
            pto_pkg::RATE_800:  rate_mult = pto_pkg::MULT_800;
            pto_pkg::RATE_1200: rate_mult = pto_pkg::MULT_1200;
            pto_pkg::RATE_1500: rate_mult = pto_pkg::MULT_1500;
            pto_pkg::RATE_1600: rate_mult = pto_pkg::MULT_1600;
            default:            rate_mult = pto_pkg::MULT_800;
        endcase
    endfunction

    // Scale the 800 Mbps figure by the rate, rounding up so no interval shrinks
    function automatic logic [6:0] auto_value(input logic [6:0] base, input logic [4:0] mult);
        logic [11:0] prod;
        prod = 12'(base) * 12'(mult) + 12'h0007;
        auto_value = prod[9:3];
    endfunction

    function automatic logic [3:0] decode(input logic [7:0] addr);
        decode = 4'h0;
        for (int i = 0; i < pto_pkg::NUM_REGS; i++) begin
            if (addr == pto_pkg::REG_OFS[i]) begin
                decode = {1'b1, 3'(i)};
            end
        end
    endfunction

    assign {hit, hit_idx} = decode(ADDR);

    always_comb begin
        for (int i = 0; i < pto_pkg::NUM_REGS; i++) begin
            eff[i] = ovr_q[i] ? val_q[i] : auto_q[i];
        end
    end

    // Automatic values follow the selected lane rate in every cycle with CE high, and hold while CE is low
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < pto_pkg::NUM_REGS; i++) begin
                auto_q[i] <= pto_pkg::REG_RST[i];
            end
        end else if (CE) begin
            for (int i = 0; i < pto_pkg::NUM_REGS; i++) begin
                auto_q[i] <= auto_value(pto_pkg::REG_RST[i], rate_mult(LANE_RATE));
            end
        end
    end

    // Override bits always writable
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < pto_pkg::NUM_REGS; i++) begin
                ovr_q[i] <= pto_pkg::RST_OVERRIDE;
            end
        end else if (CE && WR && hit) begin
            ovr_q[hit_idx] <= WDATA[pto_pkg::OVR_BIT];
        end
    end

    // Software value lands only when the same write leaves override set
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < pto_pkg::NUM_REGS; i++) begin
                val_q[i] <= pto_pkg::REG_RST[i];
            end
        end else if (CE && WR && hit && WDATA[pto_pkg::OVR_BIT]) begin
            val_q[hit_idx] <= WDATA[pto_pkg::VAL_MSB:0];
        end
    end

    // Read data stands for the one cycle after the read strobe
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_q <= 8'h00;
        end else if (CE) begin
            if (RD && hit) begin
                rdata_q <= {ovr_q[hit_idx], eff[hit_idx]};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            timing_q <= '{pto_pkg::RST_P1_CLK_ZERO, pto_pkg::RST_P1_CLK_PREP,
                          pto_pkg::RST_P0_LP_PULSE, pto_pkg::RST_P0_DATA_EXIT,
                          pto_pkg::RST_P0_DATA_TRL, pto_pkg::RST_P0_DATA_ZERO,
                          pto_pkg::RST_P0_DATA_PREP, pto_pkg::RST_P0_CLK_POST};
        end else if (CE) begin
            timing_q.p0_clk_post   <= eff[0];
            timing_q.p0_data_prep  <= eff[1];
            timing_q.p0_data_zero  <= eff[2];
            timing_q.p0_data_trail <= eff[3];
            timing_q.p0_data_exit  <= eff[4];
            timing_q.p0_lp_pulse   <= eff[5];
            timing_q.p1_clk_prep   <= eff[6];
            timing_q.p1_clk_zero   <= eff[7];
        end
    end

    assign RDATA  = rdata_q;
    assign TIMING = timing_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    clk_post_out_a: assert property (
        CE |=> TIMING.p0_clk_post == ($past(ovr_q[0]) ? $past(val_q[0]) : $past(auto_q[0])))
        else $error("port 0 clock-post output wrong");

    data_prep_out_a: assert property (
        CE |=> TIMING.p0_data_prep == ($past(ovr_q[1]) ? $past(val_q[1]) : $past(auto_q[1])))
        else $error("port 0 data-prepare output wrong");

    data_zero_out_a: assert property (
        CE && WR && ADDR == pto_pkg::OFS_P0_DATA_ZERO && WDATA[7] ##1 CE
        |=> TIMING.p0_data_zero == $past(WDATA[6:0], 2))
        else $error("port 0 data-zero override not applied");

    data_trail_out_a: assert property (
        CE |=> TIMING.p0_data_trail == ($past(ovr_q[3]) ? $past(val_q[3]) : $past(auto_q[3])))
        else $error("port 0 data-trail output wrong");

    data_exit_out_a: assert property (
        CE && !ovr_q[4] |=> TIMING.p0_data_exit == $past(auto_q[4]))
        else $error("port 0 data-exit not automatic");

    lp_pulse_out_a: assert property (
        CE |=> TIMING.p0_lp_pulse == ($past(ovr_q[5]) ? $past(val_q[5]) : $past(auto_q[5])))
        else $error("port 0 low-power pulse output wrong");

    clk_prep_out_a: assert property (
        CE && ovr_q[6] |=> TIMING.p1_clk_prep == $past(val_q[6]))
        else $error("port 1 clock-prepare override ignored");

    clk_zero_out_a: assert property (
        CE |=> TIMING.p1_clk_zero == ($past(ovr_q[7]) ? $past(val_q[7]) : $past(auto_q[7])))
        else $error("port 1 clock-zero output wrong");

    auto_write_ignored_a: assert property (
        CE && WR && hit && !WDATA[7] |=> !ovr_q[$past(hit_idx)]
        && val_q[$past(hit_idx)] == $past(val_q[hit_idx]))
        else $error("value write taken while override clear");

    auto_readback_a: assert property (
        CE && RD && hit && !ovr_q[hit_idx] |=> RDATA == {1'b0, $past(auto_q[hit_idx])})
        else $error("read did not return automatic value");

    ovr_write_read_a: assert property (
        CE && WR && hit && WDATA[7] ##1 CE && RD && ADDR == $past(ADDR) |=> RDATA == $past(WDATA, 2))
        else $error("override value not read back");

    rate_800_reset_a: assert property (
        CE && LANE_RATE == pto_pkg::RATE_800 |=> auto_q[7] == pto_pkg::RST_P1_CLK_ZERO
        && auto_q[0] == pto_pkg::RST_P0_CLK_POST)
        else $error("800 Mbps automatic values differ from reset");

    rate_change_a: assert property (
        CE && LANE_RATE != $past(LANE_RATE) && !ovr_q[2] ##1 CE && !ovr_q[2]
        |=> TIMING.p0_data_zero == auto_value(pto_pkg::RST_P0_DATA_ZERO, rate_mult($past(LANE_RATE, 2))))
        else $error("automatic value did not follow rate");

    rate_keep_ovr_a: assert property (
        CE && ovr_q[7] && !WR ##1 CE |=> TIMING.p1_clk_zero == $past(val_q[7], 2))
        else $error("overridden value changed with rate");

    // A low clock enable must hold every output, whatever the inputs do
    ce_freeze_a: assert property (
        !CE |=> $stable(TIMING) && $stable(RDATA))
        else $error("outputs moved while clock enable low");

    ovr_set_c: cover property (CE && WR && hit && WDATA[7] ##1 CE && RD && hit);
    rate_sw_c: cover property (CE && LANE_RATE == pto_pkg::RATE_1600 ##[1:4] CE && !ovr_q[0]);
    auto_rd_c: cover property (CE && RD && hit && !ovr_q[hit_idx]);
    ignore_c:  cover property (CE && WR && hit && !WDATA[7] && ovr_q[hit_idx]);

endmodule

`default_nettype wire

// ### shared/pto_pkg.sv
`default_nettype none

package pto_pkg;

    localparam int NUM_REGS = 8;
    localparam int VAL_W    = 7;
    localparam int OVR_BIT  = 7;
    localparam int VAL_MSB  = 6;

    // Register offsets
    localparam logic [7:0] OFS_P0_CLK_POST  = 8'h43;
    localparam logic [7:0] OFS_P0_DATA_PREP = 8'h44;
    localparam logic [7:0] OFS_P0_DATA_ZERO = 8'h45;
    localparam logic [7:0] OFS_P0_DATA_TRL  = 8'h46;
    localparam logic [7:0] OFS_P0_DATA_EXIT = 8'h47;
    localparam logic [7:0] OFS_P0_LP_PULSE  = 8'h48;
    localparam logic [7:0] OFS_P1_CLK_PREP  = 8'h60;
    localparam logic [7:0] OFS_P1_CLK_ZERO  = 8'h61;

    // Value field reset values, equal to the automatic values at 800 Mbps
    localparam logic [6:0] RST_P0_CLK_POST  = 7'h0a;
    localparam logic [6:0] RST_P0_DATA_PREP = 7'h06;
    localparam logic [6:0] RST_P0_DATA_ZERO = 7'h0c;
    localparam logic [6:0] RST_P0_DATA_TRL  = 7'h08;
    localparam logic [6:0] RST_P0_DATA_EXIT = 7'h0b;
    localparam logic [6:0] RST_P0_LP_PULSE  = 7'h06;
    localparam logic [6:0] RST_P1_CLK_PREP  = 7'h05;
    localparam logic [6:0] RST_P1_CLK_ZERO  = 7'h1b;
    localparam logic       RST_OVERRIDE     = 1'h0;

    localparam logic [7:0] REG_OFS [NUM_REGS] = '{
        OFS_P0_CLK_POST, OFS_P0_DATA_PREP, OFS_P0_DATA_ZERO, OFS_P0_DATA_TRL,
        OFS_P0_DATA_EXIT, OFS_P0_LP_PULSE, OFS_P1_CLK_PREP, OFS_P1_CLK_ZERO};
    localparam logic [6:0] REG_RST [NUM_REGS] = '{
        RST_P0_CLK_POST, RST_P0_DATA_PREP, RST_P0_DATA_ZERO, RST_P0_DATA_TRL,
        RST_P0_DATA_EXIT, RST_P0_LP_PULSE, RST_P1_CLK_PREP, RST_P1_CLK_ZERO};

    // Lane rate selection and its multiple of 100 Mbps
    typedef enum logic [2:0] {
        RATE_400, RATE_800, RATE_1200, RATE_1500, RATE_1600
    } pto_rate_t;

    localparam logic [4:0] MULT_400  = 5'h04;
    localparam logic [4:0] MULT_800  = 5'h08;
    localparam logic [4:0] MULT_1200 = 5'h0c;
    localparam logic [4:0] MULT_1500 = 5'h0f;
    localparam logic [4:0] MULT_1600 = 5'h10;

    // Timing parameters handed to the transmitter timing logic
    typedef struct packed {
        logic [6:0] p1_clk_zero;
        logic [6:0] p1_clk_prep;
        logic [6:0] p0_lp_pulse;
        logic [6:0] p0_data_exit;
        logic [6:0] p0_data_trail;
        logic [6:0] p0_data_zero;
        logic [6:0] p0_data_prep;
        logic [6:0] p0_clk_post;
    } pto_timing_t;

endpackage

`default_nettype wire

// ### tb/pto_timing_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pto_timing_regs_tb;

    logic                 clk;
    logic                 reset_n;
    logic                 ce;
    pto_pkg::pto_rate_t   lane_rate;
    logic [7:0]           addr;
    logic [7:0]           wdata;
    logic                 wr;
    logic                 rd;
    logic [7:0]           rdata;
    pto_pkg::pto_timing_t timing;
    int                   errors;
    int                   n_compared;
    int                   rate;
    logic                 ovr [8];
    logic [6:0]           sw [8];

    pto_timing_regs dut (
        .CLK       (clk),
        .RESET_N   (reset_n),
        .CE        (ce),
        .LANE_RATE (lane_rate),
        .ADDR      (addr),
        .WDATA     (wdata),
        .WR        (wr),
        .RD        (rd),
        .RDATA     (rdata),
        .TIMING    (timing)
    );

    always #5 clk = ~clk;

    // Automatic value scales the 800 Mbps value by the rate, rounded up
    function automatic logic [6:0] auto_val(int i);
        int m;
        case (rate)
            0: m = 4;
            2: m = 12;
            3: m = 15;
            4: m = 16;
            default: m = 8;
        endcase
        return 7'((pto_pkg::REG_RST[i] * m + 7) / 8);
    endfunction

    function automatic logic [7:0] exp_reg(int i);
        return {ovr[i], ovr[i] ? sw[i] : auto_val(i)};
    endfunction

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic check_all();
        logic [7:0] v;
        logic [7:0] e;
        for (int i = 0; i < 8; i++) begin
            rd_reg(pto_pkg::REG_OFS[i], v);
            e = exp_reg(i);
            check("register", v, e);
            check("timing", {1'b0, timing[i*7 +: 7]}, {1'b0, e[6:0]});
        end
    endtask

    task automatic finish_test();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        finish_test();
    end

    initial begin
        logic [7:0] w;
        logic [7:0] unmapped [4];
        unmapped = '{8'h42, 8'h49, 8'h5f, 8'h62};
        clk = 1'b0;
        reset_n = 1'b0;
        ce = 1'b1;
        lane_rate = pto_pkg::RATE_800;
        rate = 1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        errors = 0;
        n_compared = 0;
        for (int i = 0; i < 8; i++) begin
            ovr[i] = 1'b0;
            sw[i] = 7'h00;
        end
        void'($urandom(32'ha5dddbd5));
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        check_all();
        for (int r = 0; r < 8; r++) begin
            // Random bytes mix override set, cleared and ignored values
            for (int i = 0; i < 8; i++) begin
                w = 8'($urandom);
                wr_reg(pto_pkg::REG_OFS[i], w);
                ovr[i] = w[7];
                if (w[7]) begin
                    sw[i] = w[6:0];
                end
            end
            check_all();
            @(posedge clk);
            lane_rate <= pto_pkg::pto_rate_t'(3'(r));
            rate = r;
            repeat (3) @(posedge clk);
            check_all();
            rd_reg(unmapped[r % 4], w);
            check("unmapped", w, 8'h00);
        end
        // Frozen clock enable: a rate change must not reach the outputs
        @(posedge clk);
        ce        <= 1'b0;
        lane_rate <= pto_pkg::RATE_1600;
        repeat (4) @(posedge clk);
        #1;
        for (int i = 0; i < 8; i++) begin
            w = exp_reg(i);
            check("frozen", {1'b0, timing[i*7 +: 7]}, {1'b0, w[6:0]});
        end
        @(posedge clk);
        ce <= 1'b1;
        rate = 4;
        repeat (3) @(posedge clk);
        check_all();
        finish_test();
    end

endmodule

`default_nettype wire
